// ===== core/bomh_handler.sv
`timescale 1ns/1ps
// What this block does
// - Override frame: id, control, value, checksum.
// - Control bits 1-2 select override mode.
// - Control bit 3 selects retarder or fueling.
// - Control bit 5 inhibits the retarders.
// - Control bits 4, 6, 7 are ignored.
// - Value byte: speed or signed torque.
// - Override frame length depends on mode.
// - Hold mode until mode 00 or timeout.
// - Hold inhibit; disabled after reset, timeout.
// - Inhibit applies whatever the selector says.
// - Inhibit applies to every retarder type.
// - Drop requests while assisted shift runs.
// - Map torque percent to brake levels.
// - Graded levels need direct brake control.
// - Init request: id, status bits, checksum.
// - Answer init request when messaging enabled.
// - Status frame: id, active, selected, level.
// - Broadcast status ten times per second.
// - Retarder init response: type, peak, checksum.
// - Retarder response needs enable and direct brake.
// - Engine init response carries calibration bytes.
module bomh_handler
  import bomh_pkg::*;
#(
  parameter int STAT_PERIOD = STAT_CYC
) (
  // Clock, reset and clock enable.
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        ce,
  // AHB-Lite slave.
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Received message bytes from the link receiver.
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_byte,
  input  wire logic        rx_last,
  // Transmitted message bytes to the link sender.
  output logic             tx_valid,
  output logic [7:0]       tx_byte,
  output logic             tx_last,
  input  wire logic        tx_ready,
  // Transmission shift-in-progress pin.
  input  wire logic        shift_in_progress,
  // Override and brake outputs.
  output logic [1:0]       ovr_mode,
  output logic             ovr_ret_sel,
  output logic [7:0]       ovr_value,
  output logic             retarder_inhibit,
  output logic [1:0]       brake_level,
  output logic             brake_zero
);

  //////////////////////////////////////////////////////////////////////
  // Declarations.
  bomh_cfg_t   cfg_q;
  bomh_ovr_t   ovr_q;
  bomh_lvl_t   lvl_q;
  bomh_txst_t  tx_st_q;
  bomh_frame_t fr_q;
  logic [31:0] tmo_reg_q, tmo_cnt_q, stat_cnt_q;
  logic [7:0]  peak_q;
  logic [7:0]  eng_q [ENG_BYTES];
  logic [7:0]  rxb_q [3];
  logic [4:0]  rx_cnt_q, tx_idx_q, tx_len;
  logic [7:0]  rx_sum_q, rx_sum_d, tx_sum_q, nxt_byte, st_byte;
  logic        sh_m_q, sh_q, zero_q;
  logic        ahb_wr_q, eng_pend_q, ret_pend_q, stat_pend_q;
  logic [7:0]  ahb_a_q;
  logic [31:0] rdata_d;
  logic        rx_end, sum_ok, ovr_ok, init_ok, tmo_exp, stat_on;
  logic        tx_go, tx_adv, eng_req, ret_req, stat_tick;
  logic [1:0]  rmode;

  //////////////////////////////////////////////////////////////////////
  // The shift pin comes from another domain; two flops before use.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sh_m_q <= 1'b0;
      sh_q   <= 1'b0;
    end else if (ce) begin
      sh_m_q <= shift_in_progress;
      sh_q   <= sh_m_q;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // AHB-Lite slave with no wait states; responses are always OKAY.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ahb_wr_q  <= 1'b0;
      ahb_a_q   <= 8'h00;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else if (ce) begin
      ahb_wr_q <= hsel && hready && htrans[1] && hwrite;
      ahb_a_q  <= haddr[7:0];
      if (hsel && hready && htrans[1] && !hwrite) begin
        hrdata <= rdata_d;
      end
    end
  end

  // Read mux; unmapped offsets read as zero.
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (haddr[7:0] == A_CTRL) begin
      rdata_d[3:0] = cfg_q;
    end else if (haddr[7:0] == A_TIMEOUT) begin
      rdata_d = tmo_reg_q;
    end else if (haddr[7:0] == A_RETPEAK) begin
      rdata_d[7:0] = peak_q;
    end else if (haddr[7:0] == A_STATUS) begin
      rdata_d[11:0]  = ovr_q;
      rdata_d[13:12] = lvl_q;
      rdata_d[14]    = zero_q;
      rdata_d[15]    = sh_q;
    end
  end

  // Register writes; data comes in the cycle after the address.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_q     <= CTRL_RST;
      tmo_reg_q <= TIMEOUT_RST;
      peak_q    <= RETPEAK_RST;
    end else if (ce && ahb_wr_q) begin
      if (ahb_a_q == A_CTRL) begin
        cfg_q <= hwdata[3:0];
      end else if (ahb_a_q == A_TIMEOUT) begin
        tmo_reg_q <= hwdata;
      end else if (ahb_a_q == A_RETPEAK) begin
        peak_q <= hwdata[7:0];
      end
    end
  end

  // Engine calibration bytes, written one at a time by index.
  for (genvar i = 0; i < ENG_BYTES; i++) begin : g_eng
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        eng_q[i] <= 8'h00;
      end else if (ce && ahb_wr_q && ahb_a_q == A_ENGDATA
                   && hwdata[12:8] == 5'(i)) begin
        eng_q[i] <= hwdata[7:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Receive side: keep the first three bytes and a running sum.
  assign rx_end   = ce && rx_valid && rx_last;
  assign rx_sum_d = rx_sum_q + rx_byte;
  assign sum_ok   = rx_sum_d == 8'h00;
  assign rmode    = rxb_q[1][CB_MODE_LSB +: 2];

  // Mode 00 frames carry no value byte, so they are one shorter.
  assign ovr_ok = rx_end && sum_ok && rxb_q[0] == MID_OVR
                  && rx_cnt_q + 5'h01 ==
                     ((rmode == 2'h0) ? LEN_SHORT : LEN_LONG)
                  && !(cfg_q.shift_type && sh_q);
  assign init_ok = rx_end && sum_ok && rxb_q[0] == MID_INIT_REQ
                   && rx_cnt_q + 5'h01 == LEN_SHORT;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_cnt_q <= 5'h00;
      rx_sum_q <= 8'h00;
      rxb_q[0] <= 8'h00;
      rxb_q[1] <= 8'h00;
      rxb_q[2] <= 8'h00;
    end else if (ce && rx_valid) begin
      if (rx_last) begin
        rx_cnt_q <= 5'h00;
        rx_sum_q <= 8'h00;
      end else begin
        if (rx_cnt_q < 5'h03) begin
          rxb_q[rx_cnt_q[1:0]] <= rx_byte;
        end
        if (rx_cnt_q != 5'h1F) begin
          rx_cnt_q <= rx_cnt_q + 5'h01;
        end
        rx_sum_q <= rx_sum_d;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Override state; the partner keeps refreshing it while needed.
  assign tmo_exp = tmo_cnt_q == 32'h0000_0001 && !ovr_ok;

  // Timeout counter restarts on every accepted request.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tmo_cnt_q <= 32'h0000_0000;
    end else if (ce) begin
      if (ovr_ok) begin
        tmo_cnt_q <= tmo_reg_q;
      end else if (tmo_cnt_q != 32'h0000_0000) begin
        tmo_cnt_q <= tmo_cnt_q - 32'h0000_0001;
      end
    end
  end

  // Control bits 4, 6 and 7 are never looked at. A fresh request
  // wins over an expiring timer.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ovr_q <= OVR_RST;
    end else if (ce) begin
      if (ovr_ok) begin
        ovr_q.mode    <= rmode;
        ovr_q.ret_sel <= rxb_q[1][CB_SEL_BIT];
        ovr_q.inhibit <= rxb_q[1][CB_INH_BIT];
        ovr_q.value   <= (rmode == 2'h0) ? 8'h00 : rxb_q[2];
      end else if (tmo_exp) begin
        ovr_q <= OVR_RST;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Brake level from the torque percentage. Negative or zero torque
  // asks for no braking; only direct control gets graded levels.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lvl_q  <= LVL_OFF;
      zero_q <= 1'b0;
    end else if (ce) begin
      lvl_q  <= LVL_OFF;
      zero_q <= 1'b0;
      if (ovr_q.mode[1] && ovr_q.ret_sel && !ovr_q.inhibit) begin
        if (ovr_q.value == 8'h00 || ovr_q.value[7]) begin
          zero_q <= 1'b1;
        end else if (!cfg_q.direct) begin
          lvl_q <= LVL_OFF;
        end else if (ovr_q.value <= PCT_LOW_MAX) begin
          lvl_q <= LVL_LOW;
        end else if (ovr_q.value <= PCT_MED_MAX) begin
          lvl_q <= LVL_MED;
        end else begin
          lvl_q <= LVL_HIGH;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Transmit requests; a new request wins over the clear at start.
  assign stat_on   = cfg_q.direct && (cfg_q.trans_en || cfg_q.abs_en);
  assign stat_tick = stat_cnt_q == 32'(STAT_PERIOD - 1);
  assign eng_req   = init_ok && cfg_q.abs_en
                     && rxb_q[1][IR_ENG_BIT];
  assign ret_req   = init_ok && cfg_q.abs_en && cfg_q.direct
                     && rxb_q[1][IR_RET_BIT];
  assign tx_go     = tx_st_q == TX_IDLE
                     && ((fr_q == FR_ENG && eng_pend_q)
                     || (fr_q == FR_RET && ret_pend_q && !eng_pend_q)
                     || (fr_q == FR_STAT && stat_pend_q
                         && !eng_pend_q && !ret_pend_q));

  // Ten-per-second broadcast timer.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stat_cnt_q <= 32'h0000_0000;
    end else if (ce) begin
      if (!stat_on || stat_tick) begin
        stat_cnt_q <= 32'h0000_0000;
      end else begin
        stat_cnt_q <= stat_cnt_q + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      eng_pend_q  <= 1'b0;
      ret_pend_q  <= 1'b0;
      stat_pend_q <= 1'b0;
    end else if (ce) begin
      if (eng_req) begin
        eng_pend_q <= 1'b1;
      end else if (tx_go && fr_q == FR_ENG) begin
        eng_pend_q <= 1'b0;
      end
      if (ret_req) begin
        ret_pend_q <= 1'b1;
      end else if (tx_go && fr_q == FR_RET) begin
        ret_pend_q <= 1'b0;
      end
      if (stat_on && stat_tick) begin
        stat_pend_q <= 1'b1;
      end else if (tx_go && fr_q == FR_STAT) begin
        stat_pend_q <= 1'b0;
      end
    end
  end

  // Frame choice while idle: engine, then retarder, then status.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fr_q <= FR_ENG;
    end else if (ce && tx_st_q == TX_IDLE) begin
      if (eng_pend_q) begin
        fr_q <= FR_ENG;
      end else if (ret_pend_q) begin
        fr_q <= FR_RET;
      end else begin
        fr_q <= FR_STAT;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Frame content. tx_go waits until the frame choice agrees with the
  // pending flags, so the first byte always matches the frame.
  assign st_byte = {(lvl_q == LVL_HIGH) ? LVC_HIGH :
                    (lvl_q == LVL_MED)  ? LVC_MED  :
                    (lvl_q == LVL_LOW)  ? LVC_LOW  : LVC_OFF,
                    2'b00, ovr_q.mode[1] && ovr_q.ret_sel,
                    lvl_q != LVL_OFF};
  assign tx_len  = (fr_q == FR_ENG) ? ENG_LEN :
                   (fr_q == FR_RET) ? LEN_LONG : LEN_SHORT;
  assign tx_adv  = tx_st_q == TX_SEND && tx_ready;

  always_comb begin
    nxt_byte = 8'h00;
    if (tx_idx_q + 5'h02 == tx_len) begin
      nxt_byte = 8'h00 - (tx_sum_q + tx_byte);
    end else if (fr_q == FR_ENG) begin
      nxt_byte = eng_q[tx_idx_q];
    end else if (fr_q == FR_RET) begin
      nxt_byte = (tx_idx_q == 5'h00) ? RET_TYPE : peak_q;
    end else begin
      nxt_byte = st_byte;
    end
  end

  // Byte sender; each byte stands until tx_ready takes it.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_st_q  <= TX_IDLE;
      tx_idx_q <= 5'h00;
      tx_sum_q <= 8'h00;
      tx_valid <= 1'b0;
      tx_byte  <= 8'h00;
      tx_last  <= 1'b0;
    end else if (ce) begin
      if (tx_go) begin
        tx_st_q  <= TX_SEND;
        tx_idx_q <= 5'h00;
        tx_sum_q <= 8'h00;
        tx_valid <= 1'b1;
        tx_last  <= 1'b0;
        tx_byte  <= (fr_q == FR_ENG) ? MID_ENG_INIT :
                    (fr_q == FR_RET) ? MID_RET_INIT :
                    MID_RET_STAT;
      end else if (tx_adv && tx_last) begin
        tx_st_q  <= TX_IDLE;
        tx_valid <= 1'b0;
        tx_last  <= 1'b0;
      end else if (tx_adv) begin
        tx_idx_q <= tx_idx_q + 5'h01;
        tx_sum_q <= tx_sum_q + tx_byte;
        tx_byte  <= nxt_byte;
        tx_last  <= tx_idx_q + 5'h02 == tx_len;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // One inhibit drives every retarder type alike.
  assign ovr_mode         = ovr_q.mode;
  assign ovr_ret_sel      = ovr_q.ret_sel;
  assign ovr_value        = ovr_q.value;
  assign retarder_inhibit = ovr_q.inhibit;
  assign brake_level      = lvl_q;
  assign brake_zero       = zero_q;

  //////////////////////////////////////////////////////////////////////
  // Checks on the block's own behaviour.
  property p_bad_sum;
    @(posedge hclk) disable iff (!hresetn)
    rx_end && !sum_ok && !tmo_exp |=> $stable(ovr_q);
  endproperty
  a_bad_sum: assert property (p_bad_sum)
    else $error("Frame with bad checksum changed override state.");

  property p_mode_off;
    @(posedge hclk) disable iff (!hresetn)
    ovr_ok && rmode == 2'h0 |=> ovr_mode == 2'h0 && ovr_value == 8'h00;
  endproperty
  a_mode_off: assert property (p_mode_off)
    else $error("Mode 00 request did not end the override.");

  property p_shift_drop;
    @(posedge hclk) disable iff (!hresetn)
    ce && cfg_q.shift_type && sh_q && !tmo_exp |=> $stable(ovr_q);
  endproperty
  a_shift_drop: assert property (p_shift_drop)
    else $error("Request taken during assisted gear shift.");

  property p_timeout;
    @(posedge hclk) disable iff (!hresetn)
    ce && tmo_exp |=> !retarder_inhibit && ovr_mode == 2'h0;
  endproperty
  a_timeout: assert property (p_timeout)
    else $error("Timeout did not restore defaults.");

  property p_indirect;
    @(posedge hclk) disable iff (!hresetn)
    ce && !cfg_q.direct |=> brake_level == LVL_OFF;
  endproperty
  a_indirect: assert property (p_indirect)
    else $error("Graded braking without direct brake control.");

  property p_low;
    @(posedge hclk) disable iff (!hresetn)
    ce && cfg_q.direct && ovr_q.mode == 2'h2 && ovr_q.ret_sel
    && !ovr_q.inhibit && ovr_q.value == 8'h21 |=> brake_level == LVL_LOW;
  endproperty
  a_low: assert property (p_low)
    else $error("Torque 33 percent did not give low braking.");

  property p_ret_resp;
    @(posedge hclk) disable iff (!hresetn)
    tx_go && ce && fr_q == FR_RET |=> tx_byte == MID_RET_INIT
    && cfg_q.direct && tx_valid;
  endproperty
  a_ret_resp: assert property (p_ret_resp)
    else $error("Retarder response sent without direct brake.");

  property p_stat_id;
    @(posedge hclk) disable iff (!hresetn)
    tx_go && ce && fr_q == FR_STAT |=> tx_byte == MID_RET_STAT
    ##1 tx_valid;
  endproperty
  a_stat_id: assert property (p_stat_id)
    else $error("Status frame opened with wrong identifier.");

endmodule

// ===== core/bomh_pkg.sv
package bomh_pkg;
  // Clock rate and the status broadcast period.
  localparam int CLK_MHZ        = 200;
  localparam int STAT_PERIOD_MS = 100;
  localparam int STAT_CYC       = STAT_PERIOD_MS * 1000 * CLK_MHZ;

  // Message identifiers, decimal 79, 81, 83, 84 and 70.
  localparam logic [7:0] MID_OVR      = 8'h4F;
  localparam logic [7:0] MID_INIT_REQ = 8'h51;
  localparam logic [7:0] MID_RET_STAT = 8'h53;
  localparam logic [7:0] MID_RET_INIT = 8'h54;
  localparam logic [7:0] MID_ENG_INIT = 8'h46;

  // Control byte fields of the override request.
  localparam int CB_MODE_LSB = 0;
  localparam int CB_SEL_BIT  = 2;
  localparam int CB_INH_BIT  = 4;

  // Initialization request bits.
  localparam int IR_ENG_BIT = 0;
  localparam int IR_RET_BIT = 3;

  // Retarder status byte and init response content.
  localparam int  ST_ACT_BIT = 0;
  localparam int  ST_SEL_BIT = 1;
  localparam int  ST_LVL_LSB = 4;
  localparam logic [3:0] LVC_OFF  = 4'h0;
  localparam logic [3:0] LVC_LOW  = 4'h5;
  localparam logic [3:0] LVC_MED  = 4'hA;
  localparam logic [3:0] LVC_HIGH = 4'hF;
  localparam logic [7:0] RET_TYPE = 8'h02;

  // Torque percentage thresholds of the brake levels.
  localparam logic [7:0] PCT_LOW_MAX = 8'h21;
  localparam logic [7:0] PCT_MED_MAX = 8'h42;

  // Frame lengths in bytes, checksum included, and the engine data byte count.
  localparam logic [4:0] LEN_SHORT = 5'h03;
  localparam logic [4:0] LEN_LONG  = 5'h04;
  localparam logic [4:0] ENG_LEN   = 5'h17;
  localparam int         ENG_BYTES = 21;

  // Register byte offsets.
  localparam logic [7:0] A_CTRL    = 8'h00;
  localparam logic [7:0] A_TIMEOUT = 8'h04;
  localparam logic [7:0] A_RETPEAK = 8'h08;
  localparam logic [7:0] A_ENGDATA = 8'h0C;
  localparam logic [7:0] A_STATUS  = 8'h10;

  // Control register bits and reset values.
  localparam int CTL_ABS_EN   = 0;
  localparam int CTL_TRANS_EN = 1;
  localparam int CTL_DIRECT   = 2;
  localparam int CTL_SHIFTTYP = 3;
  localparam logic [3:0]  CTRL_RST    = 4'h0;
  localparam logic [31:0] TIMEOUT_RST = 32'h0098_9680;
  localparam logic [7:0]  RETPEAK_RST = 8'h00;

  typedef enum logic [1:0] {
    LVL_OFF = 2'h0, LVL_LOW = 2'h1, LVL_MED = 2'h2, LVL_HIGH = 2'h3
  } bomh_lvl_t;

  typedef enum logic [1:0] {
    FR_ENG = 2'h0, FR_RET = 2'h1, FR_STAT = 2'h2
  } bomh_frame_t;

  typedef enum logic {
    TX_IDLE = 1'b0, TX_SEND = 1'b1
  } bomh_txst_t;

  typedef struct packed {
    logic [1:0] mode;
    logic       ret_sel;
    logic       inhibit;
    logic [7:0] value;
  } bomh_ovr_t;

  localparam bomh_ovr_t OVR_RST = '{2'h0, 1'b0, 1'b0, 8'h00};

  typedef struct packed {
    logic shift_type;
    logic direct;
    logic trans_en;
    logic abs_en;
  } bomh_cfg_t;
endpackage

// ===== sim/bomh_partner.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////
// Brake unit stand-in: sends request frames and drains the replies.
module bomh_partner (
  // Clock.
  input  wire logic       hclk,
  // Frames toward the handler.
  output logic            rx_valid,
  output logic [7:0]      rx_byte,
  output logic            rx_last,
  // Frames from the handler.
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_byte,
  input  wire logic       tx_last,
  output logic            tx_ready
);
  logic [8:0] got_q[$];
  bit         slow;

  // Quiet link at time zero.
  initial begin
    rx_valid = 1'b0;
    rx_byte  = 8'h00;
    rx_last  = 1'b0;
    tx_ready = 1'b0;
    slow     = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One byte per cycle; the closing byte makes the frame sum to zero.
  // A bad frame flips its lowest bit so the sum misses by one.
  task automatic send(input logic [7:0] b[$], input bit bad);
    logic [7:0] s;
    s = 8'h00;
    foreach (b[i]) s -= b[i];
    b.push_back(s ^ {7'h00, bad});
    foreach (b[i]) begin
      @(posedge hclk);
      rx_valid <= 1'b1;
      rx_byte  <= b[i];
      rx_last  <= (i == b.size() - 1);
    end
    @(posedge hclk);
    rx_valid <= 1'b0;
    rx_last  <= 1'b0;
    rx_byte  <= ~b[$];  // Idle bus must not look like the last byte.
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Reply sink; a slow unit stalls at random, as a busy link would.
  always @(posedge hclk) begin
    if (tx_valid && tx_ready)
      got_q.push_back({tx_last, tx_byte});
    tx_ready <= slow ? 1'($urandom % 2) : 1'b1;
  end
endmodule

// ===== sim/test_bomh_handler.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////
// Self-checking bench for the brake override message handler.
module test_bomh_handler
  import bomh_pkg::*;
;
  logic        hclk, hresetn, ce, hsel, hwrite, hreadyout, hresp, d;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [2:0]  hsize;
  logic [1:0]  htrans, ovr_mode, brake_level;
  logic        rx_valid, rx_last, tx_valid, tx_last, tx_ready, st_chk;
  logic [7:0]  rx_byte, tx_byte, ovr_value, peak, exp_stat, fs;
  logic        shift_in_progress, ovr_ret_sel, retarder_inhibit, brake_zero;
  logic [7:0]  eng[21];
  logic [7:0]  fr_q[$];
  logic [7:0]  tq[8] = '{8'h00, 8'h01, 8'h21, 8'h22, 8'h42, 8'h43, 8'h64,
                         8'hF6};
  logic [15:0] cs[7] = '{16'h0009, 16'h0109, 16'h0509, 16'h0609, 16'h0501,
                         16'h0506, 16'h05F8};
  int          fails, total_checks, n_eng, n_ret, n_st;

  // Free-running 200 MHz clock.
  initial hclk = 1'b0;
  always #2.5 hclk = ~hclk;

  bomh_handler #(.STAT_PERIOD(50)) u_bomh_handler (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .rx_valid(rx_valid), .rx_byte(rx_byte),
    .rx_last(rx_last), .tx_valid(tx_valid), .tx_byte(tx_byte),
    .tx_last(tx_last), .tx_ready(tx_ready),
    .shift_in_progress(shift_in_progress), .ovr_mode(ovr_mode),
    .ovr_ret_sel(ovr_ret_sel), .ovr_value(ovr_value),
    .retarder_inhibit(retarder_inhibit), .brake_level(brake_level),
    .brake_zero(brake_zero));

  bomh_partner u_partner (
    .hclk(hclk), .rx_valid(rx_valid), .rx_byte(rx_byte), .rx_last(rx_last),
    .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_last(tx_last),
    .tx_ready(tx_ready));

  ////////////////////////////////////////////////////////////////////////////
  // Counts a comparison and reports a mismatch at once.
  task automatic check(input bit ok, input string msg);
    total_checks++;
    if (!ok) begin
      fails++;
      $display("Error at %0t: %s", $time, msg);
    end
  endtask

  // Verdict and end of run.
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Single AHB-Lite transfer; read data lands in rd at the data phase end.
  task automatic ahb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h000000, a};
    hwrite <= wr;
    @(posedge hclk);
    while (hreadyout !== 1'b1 && n++ < 50) @(posedge hclk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1 && n++ < 50) @(posedge hclk);
    rd = hrdata;
    check(n <= 50 && hresp === 1'b0, "bus answer");
  endtask

  // Expected {zero, level}; negative torque counts as a zero request.
  function automatic logic [2:0] grade(logic [7:0] c, v, bit dir);
    int t;
    t = $signed(v);
    if (!c[2] || !c[1]) return 3'h0;
    if (t <= 0) return 3'h4;
    if (c[4] || !dir) return 3'h0;
    return t <= 33 ? 3'h1 : t <= 66 ? 3'h2 : 3'h3;
  endfunction

  // Sends one override and compares the held outputs with the model.
  task automatic ovr(input logic [7:0] c, v, input bit dir);
    logic [2:0] g;
    g = grade(c, v, dir);
    if (c[1:0] == 2'h0)
      u_partner.send('{MID_OVR, c}, 1'b0);
    else
      u_partner.send('{MID_OVR, c, v}, 1'b0);
    repeat (3) @(posedge hclk);
    #1;
    check(ovr_mode === c[1:0], "mode");
    check(retarder_inhibit === c[4], "inhibit");
    if (c[1:0] != 2'h0)
      check(ovr_ret_sel === c[2] && ovr_value === v, "select");
    check(brake_level === g[1:0], "level");
    if (!c[4])
      check(brake_zero === g[2], "zero request");
  endtask

  // Splits replies into frames and checks each one's layout.
  task automatic scan();
    logic [8:0] w;
    while (u_partner.got_q.size() > 0) begin
      w = u_partner.got_q.pop_front();
      fr_q.push_back(w[7:0]);
      if (w[8]) begin
        fs = 8'h00;
        foreach (fr_q[i]) fs += fr_q[i];
        check(fs === 8'h00, "reply sum");
        if (fr_q[0] === MID_ENG_INIT) begin
          n_eng++;
          check(fr_q.size() == 23, "engine size");
          foreach (eng[i])
            check(fr_q[i + 1] === eng[i], "engine data");
        end else if (fr_q[0] === MID_RET_INIT) begin
          n_ret++;
          check(fr_q.size() == 4 && fr_q[1] === 8'h02
                && fr_q[2] === peak, "retarder reply");
        end else begin
          n_st++;
          check(fr_q[0] === MID_RET_STAT && fr_q.size() == 3,
                "status frame");
          if (st_chk)
            check(fr_q[1] === exp_stat, "status byte");
        end
        fr_q.delete();
      end
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    {hresetn, hsel, hwrite, shift_in_progress, st_chk} = 5'h00;
    {haddr, hwdata, htrans} = 66'h0;
    {ce, hsize} = 4'hA;
    {fails, total_checks, n_eng, n_ret, n_st} = 0;
    void'($urandom(93));
    peak = 8'($urandom);
    foreach (eng[i]) eng[i] = 8'($urandom);
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    // Reset values, a read-only place and an unmapped place.
    ahb(1'b0, A_TIMEOUT, 32'h0);
    check(rd === TIMEOUT_RST, "timeout reset");
    foreach (cs[i]) begin
      ahb(1'b1, i[0] ? A_STATUS : 8'h20, 32'hFFFFFFFF);
      ahb(1'b0, i[2:0] < 5 ? 8'(i * 4) : 8'h20 + 8'(i), 32'h0);
      check(rd === (i == 1 ? TIMEOUT_RST : 32'h0),
            "register idle value");
    end
    ahb(1'b1, A_TIMEOUT, 32'd40);
    ahb(1'b1, A_RETPEAK, {24'h0, peak});
    foreach (eng[i]) ahb(1'b1, A_ENGDATA, {19'h0, 5'(i), eng[i]});
    ahb(1'b0, A_RETPEAK, 32'h0);
    check(rd === {24'h0, peak}, "peak readback");
    $display("registers done");
    // Every mode against the torque boundaries, direct brake at random.
    for (int i = 0; i < 32; i++) begin
      d = 1'($urandom);
      ahb(1'b1, A_CTRL, {29'h0, d, 2'h1});
      ovr(8'($urandom) & 8'hFC | 8'(i % 4), tq[i / 4], d);
    end
    $display("override modes done");
    // Held while resent, dropped once resends stop.
    ahb(1'b1, A_CTRL, 32'h5);
    for (int k = 0; k < 2; k++) begin
      ovr(8'h17, 8'h30, 1'b1);
      repeat (30) @(posedge hclk);
      check(ovr_mode === 2'h3 && retarder_inhibit === 1'b1, "held");
    end
    repeat (20) @(posedge hclk);
    check(ovr_mode === 2'h0 && retarder_inhibit === 1'b0, "timeout");
    $display("timeout done");
    // Bad sum, foreign id, shift on an assisted gearbox; then two accepts.
    for (int k = 0; k < 5; k++) begin
      u_partner.send('{MID_OVR, 8'h00}, 1'b0);
      ahb(1'b1, A_CTRL, (k == 2 || k == 4) ? 32'h9 : 32'h1);
      shift_in_progress <= k == 2 || k == 3;
      repeat (4) @(posedge hclk);
      u_partner.send('{k == 1 ? 8'h50 : MID_OVR, 8'h05, 8'h40}, k == 0);
      repeat (3) @(posedge hclk);
      #1;
      check(ovr_mode === (k > 2 ? 2'h1 : 2'h0), "refusal");
      shift_in_progress <= 1'b0;
      repeat (3) @(posedge hclk);
    end
    $display("refusals done");
    // Broadcast rate and content while a medium brake request stands.
    ahb(1'b1, A_TIMEOUT, 32'd1000);
    ahb(1'b1, A_CTRL, 32'h5);
    ovr(8'h06, 8'h32, 1'b1);
    repeat (60) @(posedge hclk);
    scan();
    {n_st, st_chk, exp_stat} = {32'h0, 1'b1, 8'hA3};
    repeat (200) @(posedge hclk);
    scan();
    check(n_st >= 3 && n_st <= 5, "status rate");
    $display("status done");
    // Init requests under four control settings, slow receiver.
    u_partner.slow = 1'b1;
    st_chk = 1'b0;
    ovr(8'h00, 8'h00, 1'b1);
    repeat (30) @(posedge hclk);
    scan();
    {st_chk, exp_stat} = 9'h100;
    foreach (cs[i]) begin
      ahb(1'b1, A_CTRL, {24'h0, cs[i][15:8]});
      repeat (80) @(posedge hclk);
      scan();
      {n_eng, n_ret, n_st} = 0;
      u_partner.send('{MID_INIT_REQ, cs[i][7:0]}, 1'b0);
      repeat (250) @(posedge hclk);
      scan();
      check(n_eng == (cs[i][8] & cs[i][0]), "engine reply");
      check(n_ret == (cs[i][8] & cs[i][10] & cs[i][3]), "ret reply");
      check((n_st > 1) == ((cs[i][8] | cs[i][9]) & cs[i][10]),
            "status gate");
    end
    $display("init done");
    wrap_up();
  end

  // Watchdog far beyond the expected run length.
  initial begin
    #100000;
    fails++;
    wrap_up();
  end
endmodule
